// *** hdl/rfcsi_pkg.sv ***
// shared constants of the converter status and interrupt block
package rfcsi_pkg;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 4;
  localparam int unsigned CNT_W    = 20;
  localparam int unsigned NIBBLES  = 5;
  // register byte addresses
  localparam logic [15:0] ADDR_RUN_STAT = 16'hff91;
  localparam logic [15:0] ADDR_MC_BASE  = 16'hff92;
  localparam logic [15:0] ADDR_TC_BASE  = 16'hff97;
  localparam logic [15:0] ADDR_IRQ_EN   = 16'hffe7;
  localparam logic [15:0] ADDR_IRQ_PEND = 16'hfff7;
  // bit positions
  localparam int unsigned BIT_SEN_RUN   = 0;
  localparam int unsigned BIT_REF_RUN   = 1;
  localparam int unsigned BIT_MC_OVF    = 2;
  localparam int unsigned BIT_TB_OVF    = 3;
  localparam int unsigned BIT_SEN       = 0;
  localparam int unsigned BIT_REF       = 1;
  // counter end values, count step and zero nibble
  localparam logic [19:0] CNT_ZERO = 20'h00000;
  localparam logic [19:0] CNT_ALL1 = 20'hfffff;
  localparam logic [19:0] CNT_ONE  = 20'h00001;
  localparam logic [3:0]  NIB_ZERO = 4'h0;
  localparam logic [2:0]  SEQ_LAST = 3'h4;
endpackage : rfcsi_pkg

// *** hdl/rfcsi_if.sv ***
// cpu to converter i/o memory link with interrupt requests
`timescale 1ns/1ps
interface rfcsi_if;
  logic [15:0] addr;
  logic [3:0]  wdata;
  logic        wr;
  logic        rd;
  logic [3:0]  rdata;
  logic        sensor_irq;
  logic        ref_irq;
  modport dev (input addr, wdata, wr, rd,
               output rdata, sensor_irq, ref_irq);
  modport cpu (output addr, wdata, wr, rd,
               input rdata, sensor_irq, ref_irq);
endinterface : rfcsi_if

// *** hdl/rfcsi_dev.sv ***
// converter end: counters, run bits, overflow, enable, pending
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module rfcsi_dev
  import rfcsi_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  rfcsi_if.dev      bus,
  input  wire logic i_meas_tick,
  input  wire logic i_tb_tick,
  input  wire logic i_debug_mode,
  output logic      o_ref_running,
  output logic      o_sen_running,
  output logic      o_conv_end
);

  // ****************************************
  // state
  // ****************************************
  logic [CNT_W-1:0] meas_q;
  logic [CNT_W-1:0] meas_d;
  logic [CNT_W-1:0] tb_q;
  logic [CNT_W-1:0] tb_d;
  logic             ref_run_q;
  logic             sen_run_q;
  logic             mc_ovf_q;
  logic             tb_ovf_q;
  logic             en_sen_q;
  logic             en_ref_q;
  logic             pend_sen_q;
  logic             pend_ref_q;
  logic [3:0]       rdata_q;
  logic             end_q;

  // ****************************************
  // decode
  // ****************************************
  wire        wr_run  = bus.wr && (bus.addr == ADDR_RUN_STAT);
  wire        wr_en   = bus.wr && (bus.addr == ADDR_IRQ_EN);
  wire        wr_pend = bus.wr && (bus.addr == ADDR_IRQ_PEND);
  wire        start_ref = wr_run && bus.wdata[BIT_REF_RUN];
  wire        start_sen = wr_run && bus.wdata[BIT_SEN_RUN];
  wire        any_start = start_ref || start_sen;

  // ****************************************
  // conversion events
  // ****************************************
  wire mc_wrap = i_meas_tick && (meas_q == CNT_ALL1);
  // reference: meas reaches zero normally, timebase borrow is overflow
  wire ref_norm = ref_run_q && mc_wrap;
  wire ref_ovf  = ref_run_q && i_tb_tick
                  && (tb_q == CNT_ZERO);
  // sensor: timebase reaches zero normally, meas wrap is overflow
  wire sen_norm = sen_run_q && i_tb_tick
                  && (tb_q == CNT_ALL1);
  wire sen_ovf  = sen_run_q && mc_wrap;
  wire ref_done = ref_norm || ref_ovf;
  wire sen_done = sen_norm || sen_ovf;

  // pending sets ignore enable except in debug mode
  wire set_pref = ref_done && (!i_debug_mode || en_ref_q);
  wire set_psen = sen_done && (!i_debug_mode || en_sen_q);

  // ****************************************
  // per-nibble decode of both counters
  // ****************************************
  wire [NIBBLES-1:0] mc_hit;
  wire [NIBBLES-1:0] tc_hit;
  wire [CNT_W-1:0]   mc_wmask;
  wire [CNT_W-1:0]   tc_wmask;
  wire [CNT_W-1:0]   wdata_rep;
  wire [DATA_W-1:0]  cnt_rd [NIBBLES+1];

  assign cnt_rd[0] = NIB_ZERO;
  for (genvar g = 0; g < NIBBLES; g++)
  begin : g_nib
    wire [DATA_W-1:0] mc_nib = meas_q[g*DATA_W +: DATA_W];
    wire [DATA_W-1:0] tc_nib = tb_q[g*DATA_W +: DATA_W];
    assign mc_hit[g] = (bus.addr == ADDR_MC_BASE + 16'(g));
    assign tc_hit[g] = (bus.addr == ADDR_TC_BASE + 16'(g));
    assign mc_wmask[g*DATA_W +: DATA_W] = {DATA_W{bus.wr && mc_hit[g]}};
    assign tc_wmask[g*DATA_W +: DATA_W] = {DATA_W{bus.wr && tc_hit[g]}};
    assign wdata_rep[g*DATA_W +: DATA_W] = bus.wdata;
    assign cnt_rd[g+1] = cnt_rd[g]
                         | (mc_hit[g] ? mc_nib : NIB_ZERO)
                         | (tc_hit[g] ? tc_nib : NIB_ZERO);
  end

  // ****************************************
  // counters with nibble writes
  // ****************************************
  wire running = ref_run_q || sen_run_q;
  always_comb
  begin
    meas_d = meas_q;
    tb_d   = tb_q;
    if (running && i_meas_tick)
      meas_d = meas_q + CNT_ONE;
    if (ref_run_q && i_tb_tick)
      tb_d = tb_q - CNT_ONE;
    else if (sen_run_q && i_tb_tick)
      tb_d = tb_q + CNT_ONE;
    // a nibble write overrides counting for that nibble only
    meas_d = (meas_d & ~mc_wmask) | (wdata_rep & mc_wmask);
    tb_d   = (tb_d & ~tc_wmask) | (wdata_rep & tc_wmask);
  end

  always_ff @(posedge i_sys_clk)
  begin
    meas_q <= meas_d;
    tb_q   <= tb_d;
  end

  // ****************************************
  // run, overflow, enable and pending bits
  // ****************************************
  // run bits: a start wins over a stop in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ref_run_q <= 1'b0;
      sen_run_q <= 1'b0;
    end
    else
    begin
      ref_run_q <= start_ref || (ref_run_q && !ref_done);
      sen_run_q <= start_sen || (sen_run_q && !sen_done);
    end
  end

  // overflow flags: set wins over write-one clear or start clear
  wire clr_mc_ovf = any_start || (wr_run && bus.wdata[BIT_MC_OVF]);
  wire clr_tb_ovf = any_start || (wr_run && bus.wdata[BIT_TB_OVF]);
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      mc_ovf_q <= 1'b0;
      tb_ovf_q <= 1'b0;
    end
    else
    begin
      mc_ovf_q <= sen_ovf || (mc_ovf_q && !clr_mc_ovf);
      tb_ovf_q <= ref_ovf || (tb_ovf_q && !clr_tb_ovf);
    end
  end

  // enable bits hold their stored value
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      en_sen_q <= 1'b0;
      en_ref_q <= 1'b0;
    end
    else if (wr_en)
    begin
      en_sen_q <= bus.wdata[BIT_SEN];
      en_ref_q <= bus.wdata[BIT_REF];
    end
  end

  // pending flags: set wins over write-one clear
  wire clr_psen = wr_pend && bus.wdata[BIT_SEN];
  wire clr_pref = wr_pend && bus.wdata[BIT_REF];
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pend_sen_q <= 1'b0;
      pend_ref_q <= 1'b0;
      end_q      <= 1'b0;
    end
    else
    begin
      pend_sen_q <= set_psen || (pend_sen_q && !clr_psen);
      pend_ref_q <= set_pref || (pend_ref_q && !clr_pref);
      end_q      <= ref_done || sen_done;
    end
  end

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  logic [3:0] rsel;
  always_comb
  begin
    rsel = cnt_rd[NIBBLES];
    if (bus.addr == ADDR_RUN_STAT)
      rsel = {tb_ovf_q, mc_ovf_q, ref_run_q, sen_run_q};
    else if (bus.addr == ADDR_IRQ_EN)
      rsel = {2'b00, en_ref_q, en_sen_q};
    else if (bus.addr == ADDR_IRQ_PEND)
      rsel = {2'b00, pend_ref_q, pend_sen_q};
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      rdata_q <= NIB_ZERO;
    else if (bus.rd)
      rdata_q <= rsel;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus.rdata      = rdata_q;
  // request stands while pending or overflow and enable are set
  assign bus.sensor_irq = en_sen_q
                          && (pend_sen_q || mc_ovf_q);
  assign bus.ref_irq    = en_ref_q
                          && (pend_ref_q || tb_ovf_q);
  assign o_ref_running  = ref_run_q;
  assign o_sen_running  = sen_run_q;
  assign o_conv_end     = end_q;

endmodule : rfcsi_dev

// *** hdl/rfcsi_cpu.sv ***
// cpu end: register access port, counter loader, interrupt taking
`timescale 1ns/1ps
module rfcsi_cpu
  import rfcsi_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  rfcsi_if.cpu             bus,
  input  wire logic [15:0] i_addr,
  input  wire logic [3:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [3:0]  o_rdata,
  input  wire logic        i_mc_load,
  input  wire logic [19:0] i_mc_value,
  output logic             o_busy,
  input  wire logic        i_ei,
  input  wire logic        i_return_from_interrupt,
  output logic             o_irq_take,
  output logic             o_irq_is_ref,
  output logic             o_int_enabled
);

  // ****************************************
  // five-nibble counter loader
  // ****************************************
  logic [2:0]  seq_q;
  logic        busy_q;
  logic [19:0] val_q;
  logic        ie_q;
  logic        take_q;
  logic        isref_q;

  wire [3:0] seq_nib = val_q[{seq_q, 2'b00} +: 4];
  wire       req     = bus.sensor_irq || bus.ref_irq;
  wire       take    = ie_q && req;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      seq_q  <= 3'h0;
      busy_q <= 1'b0;
      val_q  <= CNT_ZERO;
    end
    else if (!busy_q && i_mc_load)
    begin
      seq_q  <= 3'h0;
      busy_q <= 1'b1;
      val_q  <= i_mc_value;
    end
    else if (busy_q)
    begin
      // plain stores in rising address order, no read back
      seq_q  <= seq_q + 3'h1;
      busy_q <= (seq_q != SEQ_LAST);
    end
  end

  assign bus.addr  = busy_q ? ADDR_MC_BASE + {13'h0, seq_q} : i_addr;
  assign bus.wdata = busy_q ? seq_nib : i_wdata;
  assign bus.wr    = busy_q || i_wr;
  assign bus.rd    = !busy_q && i_rd;
  assign o_rdata   = bus.rdata;
  assign o_busy    = busy_q;

  // ****************************************
  // interrupt flag: taking clears it, ei or return_from_interrupt sets it
  // ****************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ie_q    <= 1'b0;
      take_q  <= 1'b0;
      isref_q <= 1'b0;
    end
    else
    begin
      // a still-set request is taken again after re-enable
      ie_q    <= (i_ei || i_return_from_interrupt) || (ie_q && !take);
      take_q  <= take;
      if (take)
        isref_q <= !bus.sensor_irq;
    end
  end

  assign o_irq_take    = take_q;
  assign o_irq_is_ref  = isref_q;
  assign o_int_enabled = ie_q;

endmodule : rfcsi_cpu

// *** sim/rfcsi_chk.sv ***
// checker of the converter i/o link and its interrupt requests
`timescale 1ns/1ps
module rfcsi_chk
  import rfcsi_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [15:0] addr,
  input  wire logic [3:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [3:0]  rdata,
  input  wire logic        sensor_irq,
  input  wire logic        ref_irq
);
  // ****
  // shadow of the enable bits
  // ****
  logic [1:0] en_q;
  logic [1:0] en_d;
  assign en_d = (wr && addr == ADDR_IRQ_EN) ? wdata[1:0] : en_q;
  always_ff @(posedge i_sys_clk)
  begin
    en_q <= i_rst ? 2'h0 : en_d;
  end
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_rd(logic [15:0] a, logic c);
    rd && addr == a && c;
  endsequence
  a_rst_quiet: assert property ($fell(i_rst) |->
    !sensor_irq && !ref_irq) else $error("request right after reset");
  a_en_readback: assert property (s_rd(ADDR_IRQ_EN, 1'b1) |=>
    rdata == {2'h0, $past(en_q)}) else $error("enable read back");
  a_sen_masked: assert property (!en_q[0] |-> !sensor_irq)
    else $error("sensor request while masked");
  a_ref_masked: assert property (!en_q[1] |-> !ref_irq)
    else $error("reference request while masked");
  a_sen_pend_req: assert property (s_rd(ADDR_IRQ_PEND,
    en_q[0] && !sensor_irq) |=> !rdata[0]) else $error("sensor pend");
  a_ref_pend_req: assert property (s_rd(ADDR_IRQ_PEND,
    en_q[1] && !ref_irq) |=> !rdata[1]) else $error("ref pend");
  a_mc_ovf_req: assert property (s_rd(ADDR_RUN_STAT,
    en_q[0] && !sensor_irq) |=> !rdata[2]) else $error("meas overflow");
  a_tb_ovf_req: assert property (s_rd(ADDR_RUN_STAT,
    en_q[1] && !ref_irq) |=> !rdata[3]) else $error("tb overflow");
  a_pend_spare: assert property (s_rd(ADDR_IRQ_PEND, 1'b1) |=>
    rdata[3:2] == 2'h0) else $error("pending spare bits");
endmodule : rfcsi_chk

// *** sim/rfcsi_tb.sv ***
// bench for the converter status and interrupt link
`timescale 1ns/1ps
module rfcsi_tb
  import rfcsi_pkg::*;
();
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [15:0] u_a = 16'h0000;
  logic [3:0]  u_d = 4'h0;
  logic        u_w = 1'b0;
  logic        u_r = 1'b0;
  logic [3:0]  u_q;
  logic        mt = 1'b0;
  logic        tt = 1'b0;
  logic        dbg = 1'b0;
  logic        go = 1'b0;
  logic [19:0] lv = 20'h00000;
  logic        ei = 1'b0;
  logic        rt = 1'b0;
  logic        tk_q;
  logic        is_ref;
  logic        ref_run;
  logic        sen_run;
  logic        cend;
  logic        busy;
  logic        ie_on;
  int          compares = 0;
  int          n_mismatch = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  rfcsi_if i_rfcsi_if ();
  rfcsi_dev i_rfcsi_dev (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .bus(i_rfcsi_if), .i_meas_tick(mt), .i_tb_tick(tt),
    .i_debug_mode(dbg), .o_ref_running(ref_run), .o_sen_running(sen_run),
    .o_conv_end(cend));
  rfcsi_cpu i_rfcsi_cpu (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .bus(i_rfcsi_if), .i_addr(u_a), .i_wdata(u_d), .i_wr(u_w),
    .i_rd(u_r), .o_rdata(u_q), .i_mc_load(go), .i_mc_value(lv),
    .o_busy(busy), .i_ei(ei), .i_return_from_interrupt(rt), .o_irq_take(tk_q),
    .o_irq_is_ref(is_ref), .o_int_enabled(ie_on));
  rfcsi_chk i_rfcsi_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .addr(i_rfcsi_if.addr), .wdata(i_rfcsi_if.wdata),
    .wr(i_rfcsi_if.wr), .rd(i_rfcsi_if.rd), .rdata(i_rfcsi_if.rdata),
    .sensor_irq(i_rfcsi_if.sensor_irq), .ref_irq(i_rfcsi_if.ref_irq));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic w(input logic [15:0] a, input logic [3:0] d);
    @(posedge i_sys_clk);
    u_a <= a;
    u_d <= d;
    u_w <= 1'b1;
    @(posedge i_sys_clk);
    u_w <= 1'b0;
  endtask : w
  task automatic r(input logic [15:0] a, input logic [3:0] e);
    @(posedge i_sys_clk);
    u_a <= a;
    u_r <= 1'b1;
    @(posedge i_sys_clk);
    u_r <= 1'b0;
    #1;
    chk(u_q, e);
  endtask : r
  task automatic ld(input logic [19:0] x);
    @(posedge i_sys_clk);
    go <= 1'b1;
    lv <= x;
    @(posedge i_sys_clk);
    go <= 1'b0;
    #1;
    chk({3'h0, busy}, 4'h1);
    repeat (6) @(posedge i_sys_clk);
    #1;
    chk({3'h0, busy}, 4'h0);
  endtask : ld
  task automatic ltb(input logic [19:0] x);
    for (int i = 0; i < 5; i++)
      w(ADDR_TC_BASE + 16'(i), x[4*i+:4]);
  endtask : ltb
  // ticks are single spaced pulses, a slow count clock
  task automatic tk(input logic m, input logic t);
    @(posedge i_sys_clk);
    mt <= m;
    tt <= t;
    @(posedge i_sys_clk);
    mt <= 1'b0;
    tt <= 1'b0;
  endtask : tk
  task automatic irq(input logic via_ret, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge i_sys_clk);
    ei <= !via_ret;
    rt <= via_ret;
    @(posedge i_sys_clk);
    ei <= 1'b0;
    rt <= 1'b0;
    repeat (4)
    begin
      @(posedge i_sys_clk);
      #1;
      seen = seen | tk_q;
    end
    chk({3'h0, seen}, {3'h0, e});
    chk({3'h0, ie_on}, {3'h0, !e});
  endtask : irq
  task automatic end_sim;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // ****
  // scenarios
  // ****
  task automatic t_ref;
    ld(20'hffffe);
    r(ADDR_MC_BASE, 4'he);
    r(ADDR_MC_BASE + 16'h0004, 4'hf);
    ltb(20'h00005);
    w(ADDR_RUN_STAT, 4'h2);
    w(ADDR_RUN_STAT, 4'h0);
    r(ADDR_RUN_STAT, 4'h2);
    tk(1'b1, 1'b0);
    tk(1'b1, 1'b0);
    #1;
    chk({3'h0, cend}, 4'h1);
    chk({3'h0, ref_run}, 4'h0);
    r(ADDR_RUN_STAT, 4'h0);
    r(ADDR_MC_BASE, 4'h0);
    r(ADDR_IRQ_PEND, 4'h2);
    w(ADDR_IRQ_PEND, 4'h0);
    r(ADDR_IRQ_PEND, 4'h2);
    w(ADDR_IRQ_PEND, 4'h2);
    r(ADDR_IRQ_PEND, 4'h0);
  endtask : t_ref
  task automatic t_tbovf;
    ltb(20'h00000);
    w(ADDR_RUN_STAT, 4'h2);
    tk(1'b0, 1'b1);
    r(ADDR_RUN_STAT, 4'h8);
    w(ADDR_IRQ_EN, 4'h2);
    r(ADDR_IRQ_PEND, 4'h2);
    w(ADDR_IRQ_PEND, 4'h2);
    r(ADDR_IRQ_EN, 4'h2);
    chk({3'h0, i_rfcsi_if.ref_irq}, 4'h1);
    w(ADDR_RUN_STAT, 4'h0);
    r(ADDR_RUN_STAT, 4'h8);
    w(ADDR_RUN_STAT, 4'h8);
    r(ADDR_RUN_STAT, 4'h0);
    chk({3'h0, i_rfcsi_if.ref_irq}, 4'h0);
    w(ADDR_IRQ_EN, 4'h0);
    @(posedge i_sys_clk);
    dbg <= 1'b1;
    ltb(20'hfffff);
    w(ADDR_RUN_STAT, 4'h1);
    tk(1'b0, 1'b1);
    r(ADDR_RUN_STAT, 4'h0);
    r(ADDR_IRQ_PEND, 4'h0);
    @(posedge i_sys_clk);
    dbg <= 1'b0;
  endtask : t_tbovf
  task automatic t_sen;
    ld(20'hfffff);
    w(ADDR_IRQ_EN, 4'h1);
    w(ADDR_RUN_STAT, 4'h1);
    #1;
    chk({3'h0, sen_run}, 4'h1);
    tk(1'b1, 1'b0);
    r(ADDR_RUN_STAT, 4'h4);
    r(ADDR_IRQ_PEND, 4'h1);
    irq(1'b0, 1'b1);
    chk({3'h0, is_ref}, 4'h0);
    irq(1'b1, 1'b1);
    w(ADDR_IRQ_PEND, 4'h1);
    w(ADDR_RUN_STAT, 4'h2);
    r(ADDR_RUN_STAT, 4'h2);
    r(ADDR_IRQ_PEND, 4'h0);
    irq(1'b0, 1'b0);
  endtask : t_sen
  initial
  begin
    repeat (4) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    r(ADDR_IRQ_EN, 4'h0);
    r(ADDR_IRQ_PEND, 4'h0);
    r(ADDR_RUN_STAT, 4'h0);
    w(ADDR_IRQ_EN, 4'h3);
    r(ADDR_IRQ_EN, 4'h3);
    w(ADDR_IRQ_EN, 4'h0);
    t_ref();
    t_tbovf();
    t_sen();
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge i_sys_clk);
    n_mismatch++;
    end_sim();
  end
endmodule : rfcsi_tb
